// *** core/lpw_pkg.sv ***
// Shared constants, state codes and carriers of the write-burst path.
// Assumes one system clock that oversamples the memory clock pin.
package lpw_pkg;

   localparam int LANES = 2;
   localparam int DATA_W = 8 * LANES;
   localparam int COL_W = 10;
   localparam int BANK_W = 2;
   localparam int NUM_BANKS = 4;
   localparam int IDX_W = 5;
   localparam int CNT_W = 4;

   // Recovery counts in memory clock cycles.
   localparam int WR_CK_DEF = 2;
   localparam int WTR_CK_DEF = 1;

   // Programmed burst length codes and the last element index of each.
   localparam logic [1:0] BL_CODE_2 = 2'h0;
   localparam logic [1:0] BL_CODE_4 = 2'h1;
   localparam logic [1:0] BL_CODE_8 = 2'h2;
   localparam logic [1:0] BL_CODE_16 = 2'h3;
   localparam logic [IDX_W-1:0] BL_LAST_2 = 5'h01;
   localparam logic [IDX_W-1:0] BL_LAST_4 = 5'h03;
   localparam logic [IDX_W-1:0] BL_LAST_8 = 5'h07;
   localparam logic [IDX_W-1:0] BL_LAST_16 = 5'h0F;

   // Reset values of the registered outputs.
   localparam logic PIN_RESET = 1'b0;

   typedef enum logic [1:0] {
      LPW_IDLE = 2'b00,
      LPW_PRE = 2'b01,
      LPW_DATA = 2'b10,
      LPW_RECOV = 2'b11
   } lpw_state_t;

   typedef struct packed {
      logic write;
      logic read;
      logic precharge;
      logic [BANK_W-1:0] bank;
      logic [COL_W-1:0] column;
      logic auto_pre;
   } lpw_cmd_t;

   typedef struct packed {
      logic valid;
      logic [BANK_W-1:0] bank;
      logic [COL_W-1:0] col_a;
      logic [COL_W-1:0] col_b;
      logic [DATA_W-1:0] data_a;
      logic [DATA_W-1:0] data_b;
      logic [LANES-1:0] en_a;
      logic [LANES-1:0] en_b;
   } lpw_pair_wr_t;

endpackage

// *** core/lpw_pin_sync.sv ***
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module lpw_pin_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A bit changes only once the second and third stages agree.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               q[i] <= s3_q[i];
            end
         end
      end
   end

endmodule
`default_nettype wire

// *** core/lpw_write_path.sv ***
// Write-burst capture path of a low-power DDR memory device.
// Assumes the memory clock and all pins are sampled by the faster clk.
`timescale 1ns/100ps
`default_nettype none
module lpw_write_path #(
   parameter int WR_CK = lpw_pkg::WR_CK_DEF,
   parameter int WTR_CK = lpw_pkg::WTR_CK_DEF
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic mem_clk,
   input wire lpw_pkg::lpw_cmd_t cmd,
   input wire logic [lpw_pkg::LANES-1:0] data_strobe,
   input wire logic [lpw_pkg::DATA_W-1:0] data_in,
   input wire logic [lpw_pkg::LANES-1:0] data_mask,
   input wire logic [lpw_pkg::NUM_BANKS-1:0] bank_open,
   input wire logic [1:0] burst_len_code,
   output lpw_pkg::lpw_pair_wr_t array_wr,
   output logic precharge_req,
   output logic [lpw_pkg::BANK_W-1:0] precharge_bank,
   output logic write_active,
   output logic recovery_done,
   output logic read_allowed,
   output logic burst_done,
   output logic [lpw_pkg::DATA_W-1:0] data_out,
   output logic [lpw_pkg::LANES-1:0] data_oe
);
   import lpw_pkg::*;

   // ------------------------------------------------------------
   // Pin sampling
   // ------------------------------------------------------------
   localparam int CMD_W = $bits(lpw_cmd_t);
   localparam int SW = 1 + CMD_W + 2 * LANES + DATA_W;

   logic [SW-1:0] raw;
   logic [SW-1:0] filt;
   logic ck_f;
   lpw_cmd_t cmd_f;
   logic [LANES-1:0] stb_f;
   logic [DATA_W-1:0] dat_f;
   logic [LANES-1:0] msk_f;

   assign raw = {mem_clk, cmd, data_strobe, data_in, data_mask};

   lpw_pin_sync #(
      .W(SW)
   ) u_sync (
      .clk(clk),
      .resetn(resetn),
      .d(raw),
      .q(filt)
   );

   assign {ck_f, cmd_f, stb_f, dat_f, msk_f} = filt;

   // ------------------------------------------------------------
   // Edge detection
   // ------------------------------------------------------------
   logic ck_prev_q;
   logic stb_prev_q;
   logic ck_rise;
   logic stb_rise;
   logic stb_fall;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ck_prev_q <= 1'b0;
         stb_prev_q <= 1'b0;
      end else begin
         ck_prev_q <= ck_f;
         stb_prev_q <= stb_f[0];
      end
   end

   assign ck_rise = ck_f & ~ck_prev_q;
   assign stb_rise = stb_f[0] & ~stb_prev_q;
   assign stb_fall = ~stb_f[0] & stb_prev_q;

   // ------------------------------------------------------------
   // Burst state and event decode
   // ------------------------------------------------------------
   lpw_state_t state_q;
   logic [IDX_W-1:0] idx_q;
   logic [BANK_W-1:0] bank_q;
   logic [COL_W-1:0] base_q;
   logic ap_q;
   logic pend_q;
   logic arm_q;
   logic [BANK_W-1:0] p_bank_q;
   logic [COL_W-1:0] p_col_q;
   logic p_ap_q;
   logic tm_wait_q;
   logic tm_active_q;
   logic [CNT_W-1:0] wr_cnt_q;
   logic [CNT_W-1:0] wtr_cnt_q;

   logic in_burst;
   logic wr_go;
   logic rd_pre;
   logic take;
   logic new_first;
   logic start_now;
   logic trunc;
   logic last_elem;
   logic post_low;
   logic rec_over;
   logic elem_odd;
   logic [IDX_W-1:0] bl_last;
   logic [COL_W-1:0] col_mask;
   logic [COL_W-1:0] col_sum;
   logic [COL_W-1:0] col_seq;
   logic [COL_W-1:0] elem_col;
   logic [LANES-1:0] elem_en;

   always_comb begin
      case (burst_len_code)
         BL_CODE_2: bl_last = BL_LAST_2;
         BL_CODE_4: bl_last = BL_LAST_4;
         BL_CODE_8: bl_last = BL_LAST_8;
         BL_CODE_16: bl_last = BL_LAST_16;
         default: bl_last = BL_LAST_2;
      endcase
   end

   // Columns wrap inside the burst-aligned block.
   assign col_mask = {{(COL_W-IDX_W){1'b0}}, bl_last};
   assign col_sum = base_q + {{(COL_W-IDX_W){1'b0}}, idx_q};
   assign col_seq = (base_q & ~col_mask) | (col_sum & col_mask);

   assign in_burst = (state_q == LPW_PRE) || (state_q == LPW_DATA);
   assign wr_go = ck_rise & cmd_f.write & bank_open[cmd_f.bank];
   assign rd_pre = ck_rise & (cmd_f.read | cmd_f.precharge);
   // First element needs a rising edge, later ones any edge.
   assign take = ((state_q == LPW_PRE) & stb_rise)
               | ((state_q == LPW_DATA) & (stb_rise | stb_fall));
   assign new_first = take & stb_rise & arm_q;
   assign start_now = pend_q & ~in_burst;
   assign trunc = rd_pre & in_burst;
   assign last_elem = take & ~new_first & ~trunc & (idx_q == bl_last);
   assign post_low = (stb_f == '0);
   assign rec_over = tm_active_q & post_low
                   & (wr_cnt_q == '0) & (wtr_cnt_q == '0);
   assign elem_odd = new_first ? 1'b0 : idx_q[0];
   assign elem_col = new_first ? p_col_q : col_seq;
   assign elem_en = ~msk_f;

   // ------------------------------------------------------------
   // Pending write command
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pend_q <= 1'b0;
         arm_q <= 1'b0;
         p_bank_q <= '0;
         p_col_q <= '0;
         p_ap_q <= 1'b0;
      end else if (wr_go) begin
         pend_q <= 1'b1;
         arm_q <= 1'b0;
         p_bank_q <= cmd_f.bank;
         p_col_q <= cmd_f.column;
         p_ap_q <= cmd_f.auto_pre;
      end else if (start_now | new_first) begin
         pend_q <= 1'b0;
         arm_q <= 1'b0;
      end else if (pend_q & in_burst & stb_fall) begin
         // The old burst keeps the element on this falling edge.
         arm_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Burst sequencing
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= LPW_IDLE;
         idx_q <= '0;
         bank_q <= '0;
         base_q <= '0;
         ap_q <= 1'b0;
      end else begin
         case (state_q)
            LPW_IDLE, LPW_RECOV: begin
               if (start_now) begin
                  state_q <= LPW_PRE;
                  idx_q <= '0;
                  bank_q <= p_bank_q;
                  base_q <= p_col_q;
                  ap_q <= p_ap_q;
               end else if (rec_over) begin
                  state_q <= LPW_IDLE;
               end
            end
            LPW_PRE, LPW_DATA: begin
               if (trunc) begin
                  // Later elements are dropped.
                  state_q <= LPW_RECOV;
                  ap_q <= 1'b0;
               end else if (new_first) begin
                  state_q <= LPW_DATA;
                  idx_q <= 5'h01;
                  bank_q <= p_bank_q;
                  base_q <= p_col_q;
                  ap_q <= p_ap_q;
               end else if (take) begin
                  idx_q <= idx_q + 5'h01;
                  state_q <= last_elem ? LPW_RECOV : LPW_DATA;
               end
            end
            default: begin
               state_q <= LPW_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pair assembly and array write
   // ------------------------------------------------------------
   logic [DATA_W-1:0] half_data_q;
   logic [LANES-1:0] half_en_q;
   logic [COL_W-1:0] half_col_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         half_data_q <= '0;
         half_en_q <= '0;
         half_col_q <= '0;
         array_wr <= '0;
      end else begin
         array_wr.valid <= 1'b0;
         if (take & ~trunc & ~elem_odd) begin
            half_data_q <= dat_f;
            half_en_q <= elem_en;
            half_col_q <= elem_col;
         end
         // Only a complete pair reaches the array.
         if (take & ~trunc & elem_odd) begin
            array_wr.valid <= 1'b1;
            array_wr.bank <= bank_q;
            array_wr.col_a <= half_col_q;
            array_wr.col_b <= elem_col;
            array_wr.data_a <= half_data_q;
            array_wr.data_b <= dat_f;
            array_wr.en_a <= half_en_q;
            array_wr.en_b <= elem_en;
         end
      end
   end

   // ------------------------------------------------------------
   // Recovery timers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tm_wait_q <= 1'b0;
         tm_active_q <= 1'b0;
         wr_cnt_q <= '0;
         wtr_cnt_q <= '0;
      end else if (start_now | new_first) begin
         tm_wait_q <= 1'b0;
         tm_active_q <= 1'b0;
      end else if (last_elem) begin
         tm_wait_q <= 1'b1;
         tm_active_q <= 1'b0;
      end else if (trunc | (tm_wait_q & ck_rise)) begin
         // Counting starts at the clock edge after the last pair.
         tm_wait_q <= 1'b0;
         tm_active_q <= 1'b1;
         wr_cnt_q <= CNT_W'(WR_CK);
         wtr_cnt_q <= CNT_W'(WTR_CK);
      end else if (tm_active_q & ck_rise) begin
         if (wr_cnt_q != '0) begin
            wr_cnt_q <= wr_cnt_q - 4'h1;
         end
         if (wtr_cnt_q != '0) begin
            wtr_cnt_q <= wtr_cnt_q - 4'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // Status and precharge outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         precharge_req <= PIN_RESET;
         precharge_bank <= '0;
         write_active <= PIN_RESET;
         recovery_done <= PIN_RESET;
         read_allowed <= PIN_RESET;
         burst_done <= PIN_RESET;
         data_out <= '0;
         data_oe <= '0;
      end else begin
         // Precharge period begins as the recovery count expires.
         precharge_req <= tm_active_q & ck_rise & ap_q
                        & (wr_cnt_q == 4'h1);
         precharge_bank <= bank_q;
         write_active <= in_burst;
         recovery_done <= tm_active_q & (wr_cnt_q == '0);
         read_allowed <= tm_active_q & (wtr_cnt_q == '0);
         burst_done <= tm_active_q & post_low
                     & ((wr_cnt_q == '0) | (wtr_cnt_q == '0));
         data_out <= '0;
         data_oe <= '0;
      end
   end

endmodule
`default_nettype wire

// *** verif/lpw_write_path_props.sv ***
// Output checks of the write-burst path.
// Assumes a bind to lpw_write_path and one clock domain.
`timescale 1ns/100ps
`default_nettype none
module lpw_write_path_props
   import lpw_pkg::*;
#(
   parameter int WR_CK = 2,
   parameter int WTR_CK = 1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire lpw_pkg::lpw_pair_wr_t array_wr,
   input wire logic precharge_req,
   input wire logic write_active,
   input wire logic recovery_done,
   input wire logic read_allowed,
   input wire logic burst_done,
   input wire logic [lpw_pkg::LANES-1:0] data_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_quiet;
      !array_wr.valid [*3];
   endsequence
   sequence s_pulse;
      precharge_req ##1 !precharge_req;
   endsequence
   AST_NO_DRIVE: assert property (data_oe == '0)
      else $error("data lines driven");
   AST_PAIR_GAP: assert property (array_wr.valid |=> s_quiet)
      else $error("pairs too close");
   AST_PAIR_COLS: assert property (array_wr.valid |->
      (array_wr.col_a[0] ? !array_wr.col_b[0]
         && array_wr.col_b[COL_W-1:4] == array_wr.col_a[COL_W-1:4]
         : array_wr.col_b == array_wr.col_a + 1'b1))
      else $error("pair columns");
   AST_PRE_PULSE: assert property (precharge_req |-> s_pulse)
      else $error("precharge pulse");
   AST_PRE_RECOV: assert property (precharge_req |->
      ##[0:2] recovery_done)
      else $error("precharge early");
   AST_WTR_FIRST: assert property ($rose(recovery_done)
      && WTR_CK <= WR_CK |-> read_allowed)
      else $error("read delay order");
   AST_DONE_COUNT: assert property ($rose(burst_done) |->
      read_allowed || recovery_done)
      else $error("burst done early");
   AST_NEW_BURST: assert property ($rose(write_active) |=>
      !recovery_done && !burst_done)
      else $error("stale status");
endmodule
bind lpw_write_path lpw_write_path_props #(.WR_CK(WR_CK), .WTR_CK(WTR_CK))
   u_props (.clk, .resetn, .array_wr, .precharge_req, .write_active,
   .recovery_done, .read_allowed, .burst_done, .data_oe);
`default_nettype wire

// *** verif/lpw_ctrl_model.sv ***
// Controller model: free memory clock, commands, strobes and write data.
// Assumes cyc and feed are each called from one bench thread.
`timescale 1ns/100ps
`default_nettype none
module lpw_ctrl_model
   import lpw_pkg::*;
(
   output logic mem_clk,
   output var lpw_pkg::lpw_cmd_t cmd,
   output logic [lpw_pkg::LANES-1:0] data_strobe,
   output logic [lpw_pkg::DATA_W-1:0] data_in,
   output logic [lpw_pkg::LANES-1:0] data_mask
);
   initial begin
      mem_clk = 1'b0;
      cmd = '0;
      data_strobe = '0;
      data_in = '0;
      data_mask = '0;
      #37;
      forever #400 mem_clk = ~mem_clk;
   end
   // Command is held a full cycle around the rise that takes it.
   task automatic cyc(lpw_cmd_t c);
      @(negedge mem_clk);
      cmd = c;
   endtask
   // Each data word is centred on its strobe edge; masked tail still toggles.
   task automatic feed(int n, int tq, logic [DATA_W-1:0] d[$],
      logic [LANES-1:0] m[$]);
      @(negedge mem_clk);
      #(200 + tq);
      for (int i = 0; i < n; i++) begin
         data_in = d[i];
         data_mask = m[i];
         #200;
         data_strobe = {LANES{~data_strobe[0]}};
         #200;
      end
      data_strobe = '0;
      data_in = ~data_in;
      data_mask = ~data_mask;
   endtask
endmodule
`default_nettype wire

// *** verif/lpw_write_path_bench.sv ***
// Self-checking bench of the write-burst path.
// Assumes lpw_ctrl_model and the bound property checker.
`timescale 1ns/100ps
`default_nettype none
module lpw_write_path_bench;
   import lpw_pkg::*;
   logic clk, resetn, mem_clk;
   lpw_cmd_t cmd;
   logic [LANES-1:0] data_strobe, data_mask, data_oe;
   logic [DATA_W-1:0] data_in, data_out;
   logic [NUM_BANKS-1:0] bank_open;
   logic [1:0] burst_len_code;
   lpw_pair_wr_t array_wr;
   logic precharge_req, write_active, recovery_done;
   logic read_allowed, burst_done;
   logic [BANK_W-1:0] precharge_bank, pre_bank;
   int err_total, compares, pre_cnt;
   lpw_pair_wr_t exp_q[$];
   logic [DATA_W-1:0] dq[$];
   logic [LANES-1:0] mq[$];

   lpw_write_path DUT (.clk, .resetn, .mem_clk, .cmd, .data_strobe,
      .data_in, .data_mask, .bank_open, .burst_len_code, .array_wr,
      .precharge_req, .precharge_bank, .write_active, .recovery_done,
      .read_allowed, .burst_done, .data_out, .data_oe);
   lpw_ctrl_model M (.mem_clk, .cmd, .data_strobe, .data_in, .data_mask);

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      #3000000;
      err_total++;
      complete_run();
   end

   task automatic check(logic [63:0] seen, logic [63:0] exp, string msg);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   task automatic complete_run();
      if (err_total == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   function automatic logic [COL_W-1:0] ecol(lpw_cmd_t c, int len, int k);
      ecol = COL_W'((c.column & ~(len - 1)) | ((c.column + k) & (len - 1)));
   endfunction
   function automatic lpw_cmd_t mk_wr(logic ap);
      mk_wr = '0;
      mk_wr.write = 1'b1;
      mk_wr.bank = BANK_W'($urandom);
      mk_wr.column = COL_W'($urandom);
      mk_wr.auto_pre = ap;
   endfunction
   task automatic fill(int n, int mfrom);
      dq.delete();
      mq.delete();
      for (int i = 0; i < n; i++) begin
         dq.push_back(DATA_W'($urandom));
         mq.push_back(i >= mfrom ? 2'h3 : LANES'($urandom));
      end
   endtask
   task automatic expect_pairs(lpw_cmd_t c, int len, int np, int off);
      lpw_pair_wr_t e;
      for (int p = 0; p < np; p++) begin
         e.valid = 1'b1;
         e.bank = c.bank;
         e.col_a = ecol(c, len, 2 * p);
         e.col_b = ecol(c, len, 2 * p + 1);
         e.data_a = dq[off + 2 * p];
         e.data_b = dq[off + 2 * p + 1];
         e.en_a = ~mq[off + 2 * p];
         e.en_b = ~mq[off + 2 * p + 1];
         exp_q.push_back(e);
      end
   endtask
   task automatic burst(lpw_cmd_t a, lpw_cmd_t b, int gap, int n, int tq);
      fork
         begin
            M.cyc(a);
            repeat (gap - 1) M.cyc('0);
            M.cyc(b);
            M.cyc('0);
         end
         M.feed(n, tq, dq, mq);
      join
   endtask
   task automatic settle();
      for (int i = 0; i < 300 && burst_done !== 1'b1; i++) @(posedge clk);
      repeat (40) @(posedge clk);
      check(exp_q.size(), 0, "pairs missing");
      check({read_allowed, recovery_done, burst_done, write_active},
         4'hE, "status");
      check({data_out, data_oe}, 0, "data lines driven");
   endtask

   always @(negedge clk) begin
      if (array_wr.valid === 1'b1) begin
         if (exp_q.size() == 0) check(1, 0, "stray pair");
         else check(array_wr, exp_q.pop_front(), "pair");
      end
      if (precharge_req === 1'b1) begin
         pre_cnt++;
         pre_bank = precharge_bank;
      end
   end

   initial begin
      lpw_cmd_t w, w2;
      int len;
      void'($urandom(32'hBA1CAAAA));
      resetn = 1'b0;
      bank_open = '0;
      burst_len_code = '0;
      err_total = 0;
      compares = 0;
      pre_cnt = 0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      bank_open <= 4'hF;
      repeat (20) @(posedge clk);
      for (int c = 0; c < 4; c++) begin
         len = 2 << c;
         burst_len_code <= 2'(c);
         w = mk_wr(c[0]);
         fill(len, len);
         expect_pairs(w, len, len / 2, 0);
         pre_cnt = 0;
         burst(w, '0, 2, len, 600 + 200 * (c % 3));
         settle();
         check(pre_cnt, c[0], "auto precharge");
         if (c[0]) check(pre_bank, w.bank, "precharge bank");
      end
      for (int c = 1; c < 3; c++) begin
         len = 2 << c;
         burst_len_code <= 2'(c);
         w = mk_wr(1'b0);
         w2 = mk_wr(1'b0);
         fill(4 + len, 99);
         expect_pairs(w, len, 2, 0);
         expect_pairs(w2, len, len / 2, 4);
         burst(w, w2, 2, 4 + len, 800);
         settle();
      end
      burst_len_code <= BL_CODE_8;
      for (int c = 0; c < 2; c++) begin
         w = mk_wr(1'b0);
         w2 = '0;
         w2.read = (c == 0);
         w2.precharge = (c == 1);
         w2.bank = w.bank;
         fill(8, 4);
         expect_pairs(w, 8, 2, 0);
         burst(w, w2, 3, 8, 800);
         settle();
      end
      bank_open[w.bank] <= 1'b0;
      pre_cnt = 0;
      w.auto_pre = 1'b1;
      fill(8, 8);
      burst(w, '0, 2, 8, 800);
      M.feed(4, 800, dq, mq);
      settle();
      check(pre_cnt, 0, "closed bank precharge");
      complete_run();
   end
endmodule
`default_nettype wire
